// ==== design/sdcs_pkg.sv ====
// constants shared by the servo digital-input command selector
package sdcs_pkg;
    // ****************************************
    // control modes
    // ****************************************
    localparam logic [7:0] MODE_POSITION = 8'h01;
    localparam logic [7:0] MODE_SPEED = 8'h02;
    localparam logic [7:0] RST_MODE = 8'h02;

    // ****************************************
    // input function codes
    // ****************************************
    localparam logic [7:0] FN_NONE = 8'h00;
    localparam logic [7:0] FN_STOP = 8'h15;
    localparam logic [7:0] FN_REV_LIMIT = 8'h16;
    localparam logic [7:0] FN_FWD_LIMIT = 8'h17;
    localparam logic [7:0] FN_SERVO_ON = 8'h65;
    localparam logic [7:0] FN_FAULT_RESET = 8'h66;
    localparam logic [7:0] FN_TRIGGER = 8'h6C;
    localparam logic [7:0] FN_TORQUE_LIMIT = 8'h6D;
    localparam logic [7:0] FN_POS_SEL0 = 8'h6F;
    localparam logic [7:0] FN_POS_SEL1 = 8'h70;
    localparam logic [7:0] FN_POS_SEL2 = 8'h71;
    localparam logic [7:0] FN_SPD_SEL0 = 8'h72;
    localparam logic [7:0] FN_SPD_SEL1 = 8'h73;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_ASSIGN_LO = 8'h04;
    localparam logic [7:0] OFS_ASSIGN_HI = 8'h08;
    localparam logic [7:0] OFS_SPEED1 = 8'h0C;
    localparam logic [7:0] OFS_SPEED2 = 8'h10;
    localparam logic [7:0] OFS_SPEED3 = 8'h14;
    localparam logic [7:0] OFS_POS_BASE = 8'h18;
    localparam logic [7:0] OFS_POS_END = 8'h38;
    localparam logic [7:0] OFS_STATUS = 8'h38;
    localparam logic [7:0] OFS_MASK = 8'h3C;
    localparam logic [7:0] OFS_CMD = 8'h40;
    localparam logic [7:0] OFS_STATE = 8'h44;

    // ****************************************
    // fields and reset values
    // ****************************************
    localparam logic [31:0] RST_ASSIGN_LO = 32'h7372_6D65;
    localparam logic [31:0] RST_ASSIGN_HI = 32'h1517_1666;
    localparam logic [31:0] SPEED_MAX = 32'h0000_EA60;
    localparam logic [31:0] SPEED_MIN = 32'hFFFF_15A0;
    localparam int ST_REV = 0;
    localparam int ST_FWD = 1;
    localparam int ST_STOP = 2;
    localparam int ST_TRIG = 3;
    localparam int ST_WIDTH = 4;
    localparam int CMD_RESTART_BIT = 0;
endpackage

// ==== design/sdcs_top.sv ====
// servo digital-input command selector with avalon-mm register slave
// Functional notes
// - mode value 02 selects speed control; new mode applies only after restart.
// - mode value 01 selects position control, also only after restart.
// - speed mode codes: 101 servo on, 109 torque limit, 114/115 speed select, 102 reset.
// - an input assigned code 0 has no function.
// - position mode codes: 108 trigger, 111/112 position select; 101, 102 unchanged.
// - position select bit 2 exists only where code 113 is assigned.
// - inputs 6-8 default to limits and stop; fault unless assignment disabled.
// - alarms clear on restart or on the fault-reset input.
// - speed select 00 analog, 01/10/11 internal presets one to three.
// - speed presets are signed, clamped to +-60000, in 0.1 rpm steps.
// - positive speed command runs clockwise, negative counterclockwise.
// - drive follows the servo-enable input to energise and stop; the code holds it off while any limit or stop alarm is latched.
// - three select bits pick one of eight position presets, started by trigger.
// - position presets are writable and taken as absolute targets.
// - logic 1 means input on, logic 0 input off.
// - any input may carry any function code.
//
// Design decisions made here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module sdcs_top
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    input wire logic [3:0] avsByteenable,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    input wire logic [7:0] digitalIn,
    output logic irq,
    output logic modeSpeed,
    output logic modePosition,
    output logic servoEnable,
    output logic torqueLimitEnable,
    output logic [1:0] speedSource,
    output logic [31:0] speedCommand,
    output logic dirCw,
    output logic dirCcw,
    output logic [2:0] positionSelect,
    output logic [31:0] positionTarget,
    output logic positionStart,
    output logic [2:0] limitStopFault
);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic fnOn(input logic [63:0] asg, input logic [7:0] din,
                                  input logic [7:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 8; i++)
            if (asg[8*i +: 8] == code && din[i])
                hit = 1'b1;
        return hit;
    endfunction

    // an assigned limit or stop input that reads off is a fault
    function automatic logic fnMiss(input logic [63:0] asg, input logic [7:0] din,
                                    input logic [7:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 8; i++)
            if (asg[8*i +: 8] == code && !din[i])
                hit = 1'b1;
        return hit;
    endfunction

    function automatic logic [31:0] mergeBe(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
            if (be[b])
                res[8*b +: 8] = wd[8*b +: 8];
        return res;
    endfunction

    function automatic logic [31:0] clampSpd(input logic [31:0] v);
        logic [31:0] res;
        res = v;
        if ($signed(v) > $signed(sdcs_pkg::SPEED_MAX))
            res = sdcs_pkg::SPEED_MAX;
        else if ($signed(v) < $signed(sdcs_pkg::SPEED_MIN))
            res = sdcs_pkg::SPEED_MIN;
        return res;
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic [7:0] din1Ff, din2Ff;
    logic waitFf, nxt_wait;
    logic [31:0] rdataFf, nxt_rdata;
    logic [7:0] pendModeFf, nxt_pendMode;
    logic [63:0] asgFf, nxt_asg;
    logic [31:0] spdFf [0:2];
    logic [31:0] nxt_spd [0:2];
    logic [31:0] posFf [0:7];
    logic [31:0] nxt_pos [0:7];
    logic [3:0] statusFf, nxt_status;
    logic [3:0] maskFf, nxt_mask;
    logic irqFf, nxt_irq;
    logic [7:0] modeActFf, nxt_modeAct;
    logic [2:0] faultFf, nxt_fault;
    logic servoFf, nxt_servo;
    logic trqFf, nxt_trq;
    logic [1:0] spdSrcFf, nxt_spdSrc;
    logic [31:0] spdCmdFf, nxt_spdCmd;
    logic cwFf, nxt_cw;
    logic ccwFf, nxt_ccw;
    logic [2:0] posSelFf, nxt_posSel;
    logic [31:0] targetFf, nxt_target;
    logic startFf, nxt_start;
    logic trigPrevFf, nxt_trigPrev;
    logic modeSpeedFf, nxt_modeSpeed;
    logic modePosFf, nxt_modePos;
    logic [3:0] statusSet;
    logic [2:0] faultCond;
    logic restartReq;
    logic isSpeed, isPos, servo_enable_in, frst, trq, trig, trigRise;
    logic [1:0] spdSel;
    logic [2:0] posSelIn;
    logic [31:0] rdVal;
    logic [31:0] modeMerge;
    logic wrAcc, rdTake, posHit;
    logic [7:0] posOff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // ****************************************
    // input synchroniser
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            din1Ff <= 8'h00;
            din2Ff <= 8'h00;
        end
        else
        begin
            din1Ff <= digitalIn;
            din2Ff <= din1Ff;
        end
    end

    // ****************************************
    // register slave
    // ****************************************
    // one wait cycle: data is set up while waitrequest is high, write lands on the edge after waitrequest drops
    always_comb
    begin
        wrAcc = avsWrite && !waitFf;
        rdTake = avsRead && waitFf;
        posOff = avsAddress - sdcs_pkg::OFS_POS_BASE;
        posHit = avsAddress >= sdcs_pkg::OFS_POS_BASE && avsAddress < sdcs_pkg::OFS_POS_END;
        modeMerge = mergeBe({24'h000000, pendModeFf}, avsWritedata, avsByteenable);
        restartReq = wrAcc && avsAddress == sdcs_pkg::OFS_CMD && avsByteenable[0]
                     && avsWritedata[sdcs_pkg::CMD_RESTART_BIT];
        nxt_wait = ((avsRead || avsWrite) && waitFf) ? 1'b0 : 1'b1;
        nxt_pendMode = pendModeFf;
        nxt_asg = asgFf;
        nxt_spd = spdFf;
        nxt_pos = posFf;
        nxt_mask = maskFf;
        nxt_status = statusFf;
        rdVal = 32'h0000_0000;
        if (posHit)
            rdVal = posFf[posOff[4:2]];
        unique case (avsAddress)
            sdcs_pkg::OFS_MODE: rdVal = {16'h0000, modeActFf, pendModeFf};
            sdcs_pkg::OFS_ASSIGN_LO: rdVal = asgFf[31:0];
            sdcs_pkg::OFS_ASSIGN_HI: rdVal = asgFf[63:32];
            sdcs_pkg::OFS_SPEED1: rdVal = spdFf[0];
            sdcs_pkg::OFS_SPEED2: rdVal = spdFf[1];
            sdcs_pkg::OFS_SPEED3: rdVal = spdFf[2];
            sdcs_pkg::OFS_STATUS: rdVal = {28'h0000000, statusFf};
            sdcs_pkg::OFS_MASK: rdVal = {28'h0000000, maskFf};
            sdcs_pkg::OFS_STATE: rdVal = {22'h000000, faultFf, posSelFf, spdSrcFf, trqFf, servoFf};
            default: ;
        endcase
        nxt_rdata = rdTake ? rdVal : rdataFf;
        if (wrAcc)
        begin
            if (posHit)
                nxt_pos[posOff[4:2]] = mergeBe(posFf[posOff[4:2]], avsWritedata, avsByteenable);
            unique case (avsAddress)
                sdcs_pkg::OFS_MODE: nxt_pendMode = modeMerge[7:0];
                sdcs_pkg::OFS_ASSIGN_LO: nxt_asg[31:0] = mergeBe(asgFf[31:0], avsWritedata, avsByteenable);
                sdcs_pkg::OFS_ASSIGN_HI: nxt_asg[63:32] = mergeBe(asgFf[63:32], avsWritedata, avsByteenable);
                sdcs_pkg::OFS_SPEED1: nxt_spd[0] = clampSpd(mergeBe(spdFf[0], avsWritedata, avsByteenable));
                sdcs_pkg::OFS_SPEED2: nxt_spd[1] = clampSpd(mergeBe(spdFf[1], avsWritedata, avsByteenable));
                sdcs_pkg::OFS_SPEED3: nxt_spd[2] = clampSpd(mergeBe(spdFf[2], avsWritedata, avsByteenable));
                sdcs_pkg::OFS_MASK: if (avsByteenable[0]) nxt_mask = avsWritedata[3:0];
                sdcs_pkg::OFS_STATUS: if (avsByteenable[0]) nxt_status = statusFf & ~avsWritedata[3:0];
                default: ;
            endcase
        end
        // a new event in the clearing cycle survives
        nxt_status = nxt_status | statusSet;
        nxt_irq = |(nxt_status & nxt_mask);
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            waitFf <= 1'b1;
            rdataFf <= 32'h0000_0000;
            pendModeFf <= sdcs_pkg::RST_MODE;
            asgFf <= {sdcs_pkg::RST_ASSIGN_HI, sdcs_pkg::RST_ASSIGN_LO};
            for (int i = 0; i < 3; i++)
                spdFf[i] <= 32'h0000_0000;
            for (int i = 0; i < 8; i++)
                posFf[i] <= 32'h0000_0000;
            statusFf <= 4'h0;
            maskFf <= 4'h0;
            irqFf <= 1'b0;
        end
        else
        begin
            waitFf <= nxt_wait;
            rdataFf <= nxt_rdata;
            pendModeFf <= nxt_pendMode;
            asgFf <= nxt_asg;
            spdFf <= nxt_spd;
            posFf <= nxt_pos;
            statusFf <= nxt_status;
            maskFf <= nxt_mask;
            irqFf <= nxt_irq;
        end
    end

    // ****************************************
    // input functions and command selection
    // ****************************************
    always_comb
    begin
        // code 0 never matches a queried function, so such an input stays inert
        servo_enable_in = fnOn(asgFf, din2Ff, sdcs_pkg::FN_SERVO_ON);
        frst = fnOn(asgFf, din2Ff, sdcs_pkg::FN_FAULT_RESET);
        trq = fnOn(asgFf, din2Ff, sdcs_pkg::FN_TORQUE_LIMIT);
        trig = fnOn(asgFf, din2Ff, sdcs_pkg::FN_TRIGGER);
        spdSel = {fnOn(asgFf, din2Ff, sdcs_pkg::FN_SPD_SEL1),
                  fnOn(asgFf, din2Ff, sdcs_pkg::FN_SPD_SEL0)};
        posSelIn = {fnOn(asgFf, din2Ff, sdcs_pkg::FN_POS_SEL2),
                    fnOn(asgFf, din2Ff, sdcs_pkg::FN_POS_SEL1),
                    fnOn(asgFf, din2Ff, sdcs_pkg::FN_POS_SEL0)};
        isSpeed = modeActFf == sdcs_pkg::MODE_SPEED;
        isPos = modeActFf == sdcs_pkg::MODE_POSITION;
        faultCond[sdcs_pkg::ST_REV] = fnMiss(asgFf, din2Ff, sdcs_pkg::FN_REV_LIMIT);
        faultCond[sdcs_pkg::ST_FWD] = fnMiss(asgFf, din2Ff, sdcs_pkg::FN_FWD_LIMIT);
        faultCond[sdcs_pkg::ST_STOP] = fnMiss(asgFf, din2Ff, sdcs_pkg::FN_STOP);
        nxt_modeAct = restartReq ? pendModeFf : modeActFf;
        // decoded from the next mode so the registered flags track modeActFf exactly
        nxt_modeSpeed = nxt_modeAct == sdcs_pkg::MODE_SPEED;
        nxt_modePos = nxt_modeAct == sdcs_pkg::MODE_POSITION;
        nxt_fault = (restartReq || frst) ? 3'b000 : faultFf;
        nxt_fault = nxt_fault | faultCond;
        // motor power needs a clean alarm state, so a limit drop also de-energises
        nxt_servo = servo_enable_in && (isSpeed || isPos) && faultFf == 3'b000;
        nxt_trq = isSpeed && trq;
        nxt_spdSrc = isSpeed ? spdSel : 2'b00;
        nxt_spdCmd = 32'h0000_0000;
        if (isSpeed && spdSel != 2'b00)
            nxt_spdCmd = spdFf[spdSel - 2'b01];
        nxt_cw = $signed(nxt_spdCmd) > 0;
        nxt_ccw = $signed(nxt_spdCmd) < 0;
        nxt_trigPrev = trig;
        trigRise = trig && !trigPrevFf;
        nxt_posSel = posSelFf;
        nxt_target = targetFf;
        nxt_start = 1'b0;
        statusSet = 4'h0;
        statusSet[2:0] = faultCond & ~faultFf;
        if (isPos && trigRise)
        begin
            nxt_posSel = posSelIn;
            nxt_target = posFf[posSelIn];
            nxt_start = 1'b1;
            statusSet[sdcs_pkg::ST_TRIG] = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            modeActFf <= sdcs_pkg::RST_MODE;
            modeSpeedFf <= sdcs_pkg::RST_MODE == sdcs_pkg::MODE_SPEED;
            modePosFf <= sdcs_pkg::RST_MODE == sdcs_pkg::MODE_POSITION;
            faultFf <= 3'b000;
            servoFf <= 1'b0;
            trqFf <= 1'b0;
            spdSrcFf <= 2'b00;
            spdCmdFf <= 32'h0000_0000;
            cwFf <= 1'b0;
            ccwFf <= 1'b0;
            posSelFf <= 3'b000;
            targetFf <= 32'h0000_0000;
            startFf <= 1'b0;
            trigPrevFf <= 1'b0;
        end
        else
        begin
            modeActFf <= nxt_modeAct;
            modeSpeedFf <= nxt_modeSpeed;
            modePosFf <= nxt_modePos;
            faultFf <= nxt_fault;
            servoFf <= nxt_servo;
            trqFf <= nxt_trq;
            spdSrcFf <= nxt_spdSrc;
            spdCmdFf <= nxt_spdCmd;
            cwFf <= nxt_cw;
            ccwFf <= nxt_ccw;
            posSelFf <= nxt_posSel;
            targetFf <= nxt_target;
            startFf <= nxt_start;
            trigPrevFf <= nxt_trigPrev;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign avsReaddata = rdataFf;
    assign avsWaitrequest = waitFf;
    assign irq = irqFf;
    assign modeSpeed = modeSpeedFf;
    assign modePosition = modePosFf;
    assign servoEnable = servoFf;
    assign torqueLimitEnable = trqFf;
    assign speedSource = spdSrcFf;
    assign speedCommand = spdCmdFf;
    assign dirCw = cwFf;
    assign dirCcw = ccwFf;
    assign positionSelect = posSelFf;
    assign positionTarget = targetFf;
    assign positionStart = startFf;
    assign limitStopFault = faultFf;

    // ****************************************
    // checks
    // ****************************************
    mode_hold_a: assert property (!restartReq |=> $stable(modeActFf))
        else $error("active mode changed without restart");
    mode_load_a: assert property (restartReq |=> modeActFf == $past(pendModeFf))
        else $error("restart did not load pending mode");
    torque_mode_a: assert property (trqFf |-> $past(isSpeed) && $past(trq))
        else $error("torque limit outside speed mode");
    null_assign_a: assert property (asgFf[7:0] == sdcs_pkg::FN_NONE && din2Ff == 8'h01
        |=> !servoFf && !trqFf && !startFf)
        else $error("unassigned input had an effect");
    limit_fault_a: assert property (faultCond != 3'b000 |=> (faultFf & $past(faultCond)) != 3'b000)
        else $error("limit or stop fault not raised");
    fault_clear_a: assert property (frst && faultCond == 3'b000 |=> faultFf == 3'b000)
        else $error("fault reset did not clear alarms");
    analog_sel_a: assert property (isSpeed && spdSel == 2'b00 |=> spdSrcFf == 2'b00 && spdCmdFf == 32'h0)
        else $error("analog source not selected");
    preset_range_a: assert property ($signed(spdFf[0]) <= $signed(sdcs_pkg::SPEED_MAX)
        && $signed(spdFf[2]) >= $signed(sdcs_pkg::SPEED_MIN))
        else $error("speed preset out of range");
    direction_a: assert property (cwFf == ($signed(spdCmdFf) > 0) && !(cwFf && ccwFf))
        else $error("direction does not match command sign");
    servo_follow_a: assert property (servoFf |-> $past(servo_enable_in))
        else $error("servo enabled without input");
    pos_start_a: assert property (isPos && trigRise |=> startFf ##1 !startFf)
        else $error("trigger did not start one move");
    sel_latch_a: assert property (!(isPos && trigRise) |=> $stable(posSelFf) && !startFf)
        else $error("position select moved without trigger edge");
    bus_wait_a: assert property ((avsRead || avsWrite) && waitFf |=> !waitFf ##1 waitFf)
        else $error("waitrequest sequence broken");
endmodule

// ==== testbench/sdcs_switch_model.sv ====
// switch bank model driving the eight digital inputs of the selector
`timescale 1ns/1ps
module sdcs_switch_model
(
    input wire logic clk,
    input wire logic [7:0] pinReq,
    output logic [7:0] digitalIn
);
    // ****************************************
    // contacts
    // ****************************************
    // a contact closes at a clock edge and stays put; 1 is ON, 0 is OFF
    // servo-on and fault-reset contacts are just levels the bench asks for
    always_ff @(posedge clk)
    begin
        digitalIn <= pinReq;
    end
endmodule

// ==== testbench/tb.sv ====
// self-checking bench for the servo digital-input command selector
`timescale 1ns/1ps
module tb;
    logic clk;
    logic resetn;
    logic [7:0] avsAddress;
    logic avsRead;
    logic avsWrite;
    logic [31:0] avsWritedata;
    logic [31:0] avsReaddata;
    logic avsWaitrequest;
    logic [7:0] pinReq;
    logic [7:0] digitalIn;
    logic irq, modeSpeed, modePosition, servoEnable, torqueLimitEnable;
    logic [1:0] speedSource;
    logic [31:0] speedCommand, positionTarget;
    logic dirCw, dirCcw, positionStart;
    logic [2:0] positionSelect, limitStopFault;
    int mismatches = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [31:0] q;
    logic [31:0] spd [4] = '{32'h0000_0000, 32'h0000_7530, 32'h0000_03E8, 32'hFFFF_8AD0};

    sdcs_top sdcs_top_inst (.clk(clk), .resetn(resetn), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
        .avsByteenable(4'hF), .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
        .digitalIn(digitalIn), .irq(irq), .modeSpeed(modeSpeed),
        .modePosition(modePosition), .servoEnable(servoEnable),
        .torqueLimitEnable(torqueLimitEnable), .speedSource(speedSource),
        .speedCommand(speedCommand), .dirCw(dirCw), .dirCcw(dirCcw),
        .positionSelect(positionSelect), .positionTarget(positionTarget),
        .positionStart(positionStart), .limitStopFault(limitStopFault));
    sdcs_switch_model sdcs_switch_model_inst (.clk(clk), .pinReq(pinReq),
        .digitalIn(digitalIn));

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // request held until waitrequest is seen low; readdata taken there
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avsAddress <= a;
        avsWrite <= w;
        avsRead <= !w;
        avsWritedata <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avsWaitrequest !== 1'b0 && n < 50);
        if (n >= 50)
            chk("waitrequest", 32'h0, 32'h1);
        q = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask

    // pin levels need three synced edges plus the contact edge
    task automatic pins(input logic [7:0] v);
        @(posedge clk);
        pinReq <= v;
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // hang guard, well above the few hundred cycles the tests need
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        int n;
        resetn = 1'b0;
        avsAddress = 8'h00;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsWritedata = 32'h0;
        pinReq = 8'h00;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        rd(sdcs_pkg::OFS_MODE, 32'h0000_0202, "mode");
        chk("modeSpeed", 32'h1, {31'h0, modeSpeed});
        rd(sdcs_pkg::OFS_ASSIGN_LO, sdcs_pkg::RST_ASSIGN_LO, "assignLo");
        rd(sdcs_pkg::OFS_ASSIGN_HI, sdcs_pkg::RST_ASSIGN_HI, "assignHi");
        chk("faults", 32'h7, {29'h0, limitStopFault});
        rd(sdcs_pkg::OFS_STATUS, 32'h0000_0007, "status");
        rd(8'h48, 32'h0, "unmapped");
        chk("irqMasked", 32'h0, {31'h0, irq});
        wr(sdcs_pkg::OFS_MASK, 32'h1);
        @(negedge clk);
        chk("irqOn", 32'h1, {31'h0, irq});
        wr(sdcs_pkg::OFS_ASSIGN_HI, 32'h0000_0066);
        pins(8'h10);
        chk("faultReset", 32'h0, {29'h0, limitStopFault});
        pins(8'h00);
        wr(sdcs_pkg::OFS_STATUS, 32'hF);
        rd(sdcs_pkg::OFS_STATUS, 32'h0, "statusW1c");
        chk("irqOff", 32'h0, {31'h0, irq});
        $display("test faults done");

        wr(sdcs_pkg::OFS_SPEED1, 32'h0001_1170);
        rd(sdcs_pkg::OFS_SPEED1, sdcs_pkg::SPEED_MAX, "clampHi");
        wr(sdcs_pkg::OFS_SPEED1, spd[1]);
        wr(sdcs_pkg::OFS_SPEED2, spd[2]);
        wr(sdcs_pkg::OFS_SPEED3, spd[3]);
        pins(8'h03);
        chk("servo", 32'h1, {31'h0, servoEnable});
        chk("torque", 32'h1, {31'h0, torqueLimitEnable});
        for (int s = 0; s < 4; s++)
        begin
            pins({4'h0, s[1:0], 2'b01});
            chk("source", s, {30'h0, speedSource});
            chk("command", spd[s], speedCommand);
            chk("cw", {31'h0, s == 1 || s == 2}, {31'h0, dirCw});
            chk("ccw", {31'h0, s == 3}, {31'h0, dirCcw});
        end
        wr(sdcs_pkg::OFS_ASSIGN_LO, 32'h7372_6D00);
        pins(8'h01);
        chk("servoNoFn", 32'h0, {31'h0, servoEnable});
        wr(sdcs_pkg::OFS_ASSIGN_HI, 32'h6500_0066);
        pins(8'h80);
        chk("servoIn8", 32'h1, {31'h0, servoEnable});
        pins(8'h00);
        chk("servoOff", 32'h0, {31'h0, servoEnable});
        $display("test speed done");

        wr(sdcs_pkg::OFS_MODE, 32'h1);
        rd(sdcs_pkg::OFS_MODE, 32'h0000_0201, "modePending");
        chk("stillSpeed", 32'h1, {31'h0, modeSpeed});
        wr(sdcs_pkg::OFS_ASSIGN_LO, 32'h706F_6C65);
        wr(sdcs_pkg::OFS_ASSIGN_HI, 32'h0000_0071);
        wr(sdcs_pkg::OFS_CMD, 32'h1);
        @(negedge clk);
        chk("modePos", 32'h1, {31'h0, modePosition});
        for (int i = 0; i < 8; i++)
            wr(sdcs_pkg::OFS_POS_BASE + 8'(4 * i), 32'h0000_1000 + i);
        for (int i = 0; i < 8; i++)
        begin
            pins({3'h0, 3'(i), 2'b01});
            pins({3'h0, 3'(i), 2'b11});
            chk("select", i, {29'h0, positionSelect});
            chk("target", 32'h0000_1000 + i, positionTarget);
        end
        pins(8'h01);
        chk("hold", 32'h7, {29'h0, positionSelect});
        @(posedge clk);
        pinReq <= 8'h03;
        n = 0;
        while (positionStart !== 1'b1 && n < 8)
        begin
            @(negedge clk);
            n++;
        end
        chk("startSeen", 32'h1, {31'h0, positionStart});
        @(negedge clk);
        chk("startPulse", 32'h0, {31'h0, positionStart});
        chk("zeroSel", 32'h0, {29'h0, positionSelect});
        rd(sdcs_pkg::OFS_STATUS, 32'h0000_0008, "statusTrig");
        $display("test position done");
        end_of_test();
    end
endmodule
